// File: hw/sdf_top.sv
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Offset cal lasts one first conversion
// - Gain cal lasts one first conversion
// - Four-bit type field selects the filter
// - Filter type resets to sinc3
// - Rate field sets rate for sinc modes
// - Sinc4 rate above ten acts as ten
// - Sinc3 modes accept rates 1 to 2047
// - Notch at mclk over 32 times rate
// - Averaging modes mean eight decimator outputs; the core outputs at every conversion the sum since the last eighth, over 8
// - Averaging first conversion has no extra delay
// - Post filters ignore rate, fixed rates
// - Rate 48 with notch gives 50/60 rejection
// - Control mode codes start system calibrations
// - Completion updates coefficient, clears flag, idles
module sdf_top
(
    input wire logic mclk, // Main clock
    input wire logic rst, // Synchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic cs_n, // Chip select, active low
    output logic data_ready // Data ready output
);

    sdf_dec_if dec ();

    logic [3:0] filter_type;
    logic [10:0] rate_divider_field;
    logic [15:0] offset_coef;
    logic [15:0] gain_coef;
    logic [15:0] sample;
    logic [31:0] result;
    logic result_pending_flag;
    logic ready_level;
    sdf_pkg::sdf_cal_e cal_state;
    sdf_pkg::sdf_cal_e next_cal_state;

    // ****************************************
    // APB decode
    // ****************************************
    wire logic wr_en = psel && penable && pwrite;
    wire logic hit_filter = (paddr == sdf_pkg::ADDR_FILTER);
    wire logic hit_control = (paddr == sdf_pkg::ADDR_CONTROL);
    wire logic hit_status = (paddr == sdf_pkg::ADDR_STATUS);
    wire logic hit_offset = (paddr == sdf_pkg::ADDR_OFFSET);
    wire logic hit_gain = (paddr == sdf_pkg::ADDR_GAIN);
    wire logic hit_sample = (paddr == sdf_pkg::ADDR_SAMPLE);
    wire logic hit_result = (paddr == sdf_pkg::ADDR_RESULT);
    wire logic mapped = hit_filter | hit_control | hit_status | hit_offset | hit_gain | hit_sample | hit_result;
    wire logic cal_busy = (cal_state != sdf_pkg::CAL_IDLE);
    wire logic [3:0] wr_mode = pwdata[sdf_pkg::MODE_W-1:0];
    wire logic [3:0] wr_type = pwdata[sdf_pkg::TYPE_LSB +: sdf_pkg::TYPE_W];
    // Coefficients are locked while a calibration owns them
    wire logic coef_lock = cal_busy;
    wire logic start_offset = wr_en && hit_control && !cal_busy && (wr_mode == sdf_pkg::MODE_SYS_OFFSET);
    wire logic start_gain = wr_en && hit_control && !cal_busy && (wr_mode == sdf_pkg::MODE_SYS_GAIN);
    wire logic cal_done = cal_busy && dec.result_valid;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (hit_filter)
            prdata = {12'h000, filter_type, 5'h00, rate_divider_field};
        else if (hit_control)
            prdata = {29'h0, cal_state};
        else if (hit_status)
            prdata = {31'h0, result_pending_flag};
        else if (hit_offset)
            prdata = {16'h0000, offset_coef};
        else if (hit_gain)
            prdata = {16'h0000, gain_coef};
        else if (hit_sample)
            prdata = {16'h0000, sample};
        else if (hit_result)
            prdata = result;
    end

    // ****************************************
    // Filter configuration
    // ****************************************
    // Codes above the last post filter fall back to sinc3
    wire logic [3:0] legal_type = (wr_type > sdf_pkg::FT_POST4) ? sdf_pkg::FT_SINC3 : wr_type;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            filter_type <= sdf_pkg::FT_SINC3;
            rate_divider_field <= sdf_pkg::RATE_RESET;
        end
        else if (wr_en && hit_filter && !cal_busy)
        begin
            filter_type <= legal_type;
            rate_divider_field <= pwdata[sdf_pkg::RATE_LSB +: sdf_pkg::RATE_W];
        end
    end

    // Modulator sample stand-in, written by software
    always_ff @(posedge mclk)
    begin
        if (rst)
            sample <= 16'h0000;
        else if (wr_en && hit_sample)
            sample <= pwdata[15:0];
    end

    // ****************************************
    // Calibration sequencer
    // ****************************************
    // A calibration is one first conversion of the chosen setup; a fresh
    // restart of the core makes the next result that first conversion
    always_comb
    begin
        next_cal_state = cal_state;
        unique case (cal_state)
            sdf_pkg::CAL_IDLE:
                if (start_offset)
                    next_cal_state = sdf_pkg::CAL_OFFSET;
                else if (start_gain)
                    next_cal_state = sdf_pkg::CAL_GAIN;
            sdf_pkg::CAL_OFFSET:
                if (cal_done)
                    next_cal_state = sdf_pkg::CAL_IDLE;
            sdf_pkg::CAL_GAIN:
                if (cal_done)
                    next_cal_state = sdf_pkg::CAL_IDLE;
            default:
                next_cal_state = sdf_pkg::CAL_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            cal_state <= sdf_pkg::CAL_IDLE;
        else
            cal_state <= next_cal_state;
    end

    // Coefficient update on completion; software writes are refused during
    // calibration (the host is trusted to order offset before gain)
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            offset_coef <= sdf_pkg::OFFSET_RESET;
            gain_coef <= sdf_pkg::GAIN_RESET;
        end
        else if (cal_done && cal_state == sdf_pkg::CAL_OFFSET)
            offset_coef <= dec.result[15:0];
        else if (cal_done && cal_state == sdf_pkg::CAL_GAIN)
            gain_coef <= dec.result[15:0];
        else if (wr_en && hit_offset && !coef_lock)
            offset_coef <= pwdata[15:0];
        else if (wr_en && hit_gain && !coef_lock)
            gain_coef <= pwdata[15:0];
    end

    // ****************************************
    // Result and pending flag
    // ****************************************
    // Flag rises as calibration starts and falls when it completes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            result_pending_flag <= 1'b0;
            result <= 32'h0000_0000;
        end
        else
        begin
            if (start_offset || start_gain)
                result_pending_flag <= 1'b1;
            else if (cal_done)
                result_pending_flag <= 1'b0;
            if (dec.result_valid && !cal_busy)
                result <= dec.result;
        end
    end

    // Data ready drops on completion only while chip select is low
    always_ff @(posedge mclk)
    begin
        if (rst)
            ready_level <= 1'b0;
        else if (start_offset || start_gain)
            ready_level <= 1'b1;
        else if (cal_done && !cs_n)
            ready_level <= 1'b0;
        else if (!cal_busy && !cs_n)
            ready_level <= 1'b0;
    end

    assign data_ready = ready_level;

    // ****************************************
    // Decimation core
    // ****************************************
    // Notch mode with rate 48 places 50 Hz main and 60 Hz extra notches;
    // the extra notch changes coefficients only, not timing
    assign dec.filter_type = filter_type;
    assign dec.rate = rate_divider_field;
    assign dec.sample = sample;
    assign dec.restart = start_offset || start_gain;

    sdf_decimator u_dec
    (
        .mclk(mclk),
        .rst(rst),
        .dec(dec)
    );

endmodule // sdf_top

// File: common/sdf_pkg.sv
package sdf_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] ADDR_FILTER = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_OFFSET = 12'h00c;
    localparam logic [11:0] ADDR_GAIN = 12'h010;
    localparam logic [11:0] ADDR_SAMPLE = 12'h014;
    localparam logic [11:0] ADDR_RESULT = 12'h018;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 11;
    localparam int TYPE_LSB = 16;
    localparam int TYPE_W = 4;
    localparam int MODE_W = 4;

    // ****************************************
    // Filter type codes
    // ****************************************
    localparam logic [3:0] FT_SINC4 = 4'h0;
    localparam logic [3:0] FT_SINC4_AVG = 4'h1;
    localparam logic [3:0] FT_SINC3 = 4'h2;
    localparam logic [3:0] FT_SINC3_NOTCH = 4'h3;
    localparam logic [3:0] FT_SINC3_AVG = 4'h4;
    localparam logic [3:0] FT_POST1 = 4'h5;
    localparam logic [3:0] FT_POST4 = 4'h8;

    // ****************************************
    // Converter control modes
    // ****************************************
    localparam logic [3:0] MODE_SYS_OFFSET = 4'h7;
    localparam logic [3:0] MODE_SYS_GAIN = 4'h8;

    // ****************************************
    // Reset values and timing counts
    // ****************************************
    localparam logic [10:0] RATE_RESET = 11'h030;
    localparam logic [10:0] RATE_SINC4_MAX = 11'h00a;
    localparam logic [15:0] OFFSET_RESET = 16'h8000;
    localparam logic [15:0] GAIN_RESET = 16'h5555;
    localparam int MCLK_PER_RATE = 32;
    localparam int AVG_COUNT = 8;
    localparam logic [12:0] POST1_CYCLES = 13'd2944;
    localparam logic [12:0] POST2_CYCLES = 13'd3200;
    localparam logic [12:0] POST3_CYCLES = 13'd3968;
    localparam logic [12:0] POST4_CYCLES = 13'd4736;

    typedef enum logic [2:0]
    {
        CAL_IDLE = 3'b001,
        CAL_OFFSET = 3'b010,
        CAL_GAIN = 3'b100
    } sdf_cal_e;

endpackage

// File: common/sdf_dec_if.sv
`timescale 1ns/1ps
// Link from the control top to the decimation core
interface sdf_dec_if;
    logic [3:0] filter_type;
    logic [10:0] rate;
    logic restart;
    logic [15:0] sample;
    logic result_valid;
    logic [31:0] result;

    modport ctrl (output filter_type, output rate, output restart, output sample,
                  input result_valid, input result);
    modport core (input filter_type, input rate, input restart, input sample,
                  output result_valid, output result);
endinterface

// File: hw/sdf_decimator.sv
`timescale 1ns/1ps
// Decimation core: each sinc conversion integrates one tick of input for
// 32 x rate ticks (one tick per main clock), post filters fixed counts; averaging modes sum 8.
module sdf_decimator
(
    input wire logic mclk, // Main clock
    input wire logic rst, // Synchronous reset
    sdf_dec_if.core dec // Control link
);

    logic [15:0] conv_len;
    logic [15:0] conv_cnt;
    logic [2:0] avg_cnt;
    logic [31:0] acc;
    logic [31:0] avg_acc;
    logic [31:0] res;
    logic res_v;

    // ****************************************
    // Conversion length selection
    // ****************************************
    wire logic is_post = (dec.filter_type >= sdf_pkg::FT_POST1) && (dec.filter_type <= sdf_pkg::FT_POST4);
    wire logic is_sinc4 = (dec.filter_type == sdf_pkg::FT_SINC4) || (dec.filter_type == sdf_pkg::FT_SINC4_AVG);
    wire logic is_avg = (dec.filter_type == sdf_pkg::FT_SINC4_AVG) || (dec.filter_type == sdf_pkg::FT_SINC3_AVG);
    // Rate above ten clamps for the fourth order modes
    wire logic [10:0] eff_rate = (is_sinc4 && dec.rate > sdf_pkg::RATE_SINC4_MAX)
                                 ? sdf_pkg::RATE_SINC4_MAX : dec.rate;
    wire logic [10:0] safe_rate = (eff_rate == 11'h000) ? 11'h001 : eff_rate;
    // First notch at mclk / (32 x rate): one conversion spans 32 x rate clocks
    wire logic [15:0] sinc_len = {safe_rate, 5'h00};
    wire logic [12:0] post_len = (dec.filter_type == sdf_pkg::FT_POST1) ? sdf_pkg::POST1_CYCLES :
                                 (dec.filter_type == 4'h6) ? sdf_pkg::POST2_CYCLES :
                                 (dec.filter_type == 4'h7) ? sdf_pkg::POST3_CYCLES : sdf_pkg::POST4_CYCLES;
    // Post filters run at a fixed rate and ignore the rate field
    assign conv_len = is_post ? {3'h0, post_len} : sinc_len;
    wire logic conv_end = (conv_cnt == conv_len - 16'h0001);
    // Sum including this clock's sample, so a conversion integrates all of its ticks
    wire logic [31:0] acc_full = acc + {16'h0000, dec.sample};

    // ****************************************
    // Integrator and conversion counter
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (rst || dec.restart)
        begin
            conv_cnt <= 16'h0000;
            acc <= 32'h0000_0000;
        end
        else
        begin
            conv_cnt <= conv_end ? 16'h0000 : conv_cnt + 16'h0001;
            acc <= conv_end ? 32'h0000_0000 : acc_full;
        end
    end

    // Averaging stage; a result is released every decimator output so the
    // first conversion costs no extra delay (sum since the last eighth output, over 8)
    always_ff @(posedge mclk)
    begin
        if (rst || dec.restart)
        begin
            avg_cnt <= 3'h0;
            avg_acc <= 32'h0000_0000;
            res <= 32'h0000_0000;
            res_v <= 1'b0;
        end
        else
        begin
            res_v <= conv_end;
            if (conv_end)
            begin
                avg_cnt <= avg_cnt + 3'h1;
                avg_acc <= (avg_cnt == 3'h7) ? 32'h0000_0000 : avg_acc + acc_full;
                res <= is_avg ? (avg_acc + acc_full) >> 3 : acc_full;
            end
        end
    end

    assign dec.result = res;
    assign dec.result_valid = res_v;

endmodule // sdf_decimator

// File: dv/sdf_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host side: APB master reaching the registers
// ****************************************
module sdf_host_model
(
    input wire logic mclk, // Main clock
    output logic psel, // APB select
    output logic penable, // APB enable
    output logic pwrite, // APB direction
    output logic [11:0] paddr, // APB address
    output logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr // APB error
);
    // Idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // One transfer; opens with an edge so a release and a new setup never share a time step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // sdf_host_model

// File: dv/sdf_top_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the filter top
// ****************************************
module sdf_top_monitor
(
    input wire logic mclk, // Main clock
    input wire logic rst, // Reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic cs_n, // Chip select
    input wire logic data_ready // Data ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic acc;
    logic go;
    logic [16:0] busy_cnt;
    // Access phase and calibration start decode
    assign acc = psel && penable;
    assign go = acc && pwrite && paddr == sdf_pkg::ADDR_CONTROL && !data_ready
        && (pwdata[3:0] == sdf_pkg::MODE_SYS_OFFSET || pwdata[3:0] == sdf_pkg::MODE_SYS_GAIN);
    // Busy time with select low; a hung calibration would run past any real length
    always_ff @(posedge mclk)
    begin
        if (rst || !data_ready)
            busy_cnt <= 17'h00000;
        else if (!cs_n)
            busy_cnt <= busy_cnt + 17'h00001;
    end
    sequence busy8;
        data_ready [*8];
    endsequence
    a_ready_high: assert property (acc |-> pready) else $error("ready low in access");
    a_unmapped_err: assert property (acc && paddr > sdf_pkg::ADDR_RESULT |-> pslverr)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (acc && paddr <= sdf_pkg::ADDR_RESULT && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped address");
    a_err_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_cal_start: assert property (go |=> data_ready) else $error("calibration did not raise ready");
    a_cal_min: assert property ($rose(data_ready) |-> busy8 ##1 busy8 ##1 busy8 ##1 busy8)
        else $error("calibration shorter than one conversion");
    a_cal_bound: assert property (busy_cnt < 17'h101d0) else $error("calibration never ends");
    a_idle_ctrl: assert property (acc && !pwrite && paddr == sdf_pkg::ADDR_CONTROL && !data_ready
        |-> prdata == 32'h00000001) else $error("not idle with ready low");
    a_drop_sel: assert property ($fell(data_ready) && !$past(rst) |-> !$past(cs_n))
        else $error("ready dropped with select high");
    a_reset_low: assert property ($fell(rst) |-> !data_ready) else $error("ready high after reset");
endmodule // sdf_top_monitor

bind sdf_top sdf_top_monitor u_sdf_top_monitor (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .data_ready(data_ready));

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic mclk, rst, cs_n, data_ready, pready, pslverr, psel, penable, pwrite, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] tt;
    int bad_count, checks, n;
    // Calibration cases: type, rate, conversion clocks
    logic [3:0] c_type [9] = '{4'h2, 4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    logic [10:0] c_rate [9] = '{11'h001, 11'h00c, 11'h00f, 11'h030, 11'h002, 11'h009, 11'h001, 11'h001, 11'h7ff};
    int c_len [9] = '{32, 320, 320, 1536, 64, 2944, 3200, 3968, 4736};

    sdf_top u_sdf_top (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cs_n(cs_n), .data_ready(data_ready));
    sdf_host_model u_sdf_host_model (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ****************************************
    // Clock, tasks
    // ****************************************
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_sdf_host_model.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        u_sdf_host_model.xfer(1'b0, a, 32'h00000000, q, e);
        chk(q, exp, "read data");
        chk({31'h0, e}, 32'h00000000, "read error");
    endtask
    // Poll ready after each edge has settled; bounded so a hang cannot stall here
    task automatic wait_idle;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (data_ready === 1'b1 && n < 6000);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog sized well above the planned run
    initial
    begin
        #400000;
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        bad_count = 0;
        checks = 0;
        rst = 1'b1;
        cs_n = 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rd(sdf_pkg::ADDR_FILTER, 32'h00020030);
        rd(sdf_pkg::ADDR_OFFSET, 32'h00008000);
        rd(sdf_pkg::ADDR_GAIN, 32'h00005555);
        rd(sdf_pkg::ADDR_CONTROL, 32'h00000001);
        u_sdf_host_model.xfer(1'b0, 12'h01c, 32'h00000000, q, e);
        chk({31'h0, e}, 32'h00000001, "unmapped error");
        $display("test reset done");
        // Every type code; undefined ones fall back to sinc3
        for (int t = 0; t < 16; t++)
        begin
            tt = (t > 8) ? sdf_pkg::FT_SINC3 : 4'(t);
            wr(sdf_pkg::ADDR_FILTER, {12'h0, 4'(t), 5'h0, 11'h005});
            rd(sdf_pkg::ADDR_FILTER, {12'h0, tt, 5'h0, 11'h005});
        end
        $display("test types done");
        // One cal per setup, offset for even i and gain for odd i, input level applied first; no internal cal to precede
        for (int i = 0; i < 9; i++)
        begin
            wr(sdf_pkg::ADDR_FILTER, {12'h0, c_type[i], 5'h0, c_rate[i]});
            wr(sdf_pkg::ADDR_SAMPLE, 32'h00000010 * i);
            wr(sdf_pkg::ADDR_CONTROL, {28'h0, i[0] ? sdf_pkg::MODE_SYS_GAIN : sdf_pkg::MODE_SYS_OFFSET});
            wait_idle();
            chk({31'h0, n >= c_len[i] && n <= c_len[i] + 3}, 32'h00000001, "cal length");
            rd(sdf_pkg::ADDR_STATUS, 32'h00000000);
        end
        $display("test timing done");
        // Writes while a gain calibration runs must be refused
        wr(sdf_pkg::ADDR_OFFSET, 32'h00008000);
        wr(sdf_pkg::ADDR_FILTER, 32'h00020040);
        wr(sdf_pkg::ADDR_CONTROL, {28'h0, sdf_pkg::MODE_SYS_GAIN});
        rd(sdf_pkg::ADDR_CONTROL, {29'h0, sdf_pkg::CAL_GAIN});
        rd(sdf_pkg::ADDR_STATUS, 32'h00000001);
        wr(sdf_pkg::ADDR_OFFSET, 32'h00001234);
        wr(sdf_pkg::ADDR_FILTER, 32'h00000000);
        wr(sdf_pkg::ADDR_CONTROL, {28'h0, sdf_pkg::MODE_SYS_OFFSET});
        wait_idle();
        rd(sdf_pkg::ADDR_OFFSET, 32'h00008000);
        rd(sdf_pkg::ADDR_FILTER, 32'h00020040);
        rd(sdf_pkg::ADDR_CONTROL, 32'h00000001);
        $display("test refuse done");
        // Select high: ready stays up although the calibration is over
        @(posedge mclk);
        cs_n <= 1'b1;
        wr(sdf_pkg::ADDR_FILTER, 32'h00020001);
        wr(sdf_pkg::ADDR_CONTROL, {28'h0, sdf_pkg::MODE_SYS_OFFSET});
        repeat (80) @(posedge mclk);
        rd(sdf_pkg::ADDR_STATUS, 32'h00000000);
        rd(sdf_pkg::ADDR_RESULT, 32'h00001000);
        chk({31'h0, data_ready}, 32'h00000001, "ready held");
        $display("test select done");
        finish_test();
    end
endmodule // tb_top
